// >>> src/acm_array.sv
/*
 * Counter array: shared 16-bit counter, three capture/compare modules, an
 * Avalon-MM register slave with one wait state and a level interrupt.
 * Assumes one clock, synchronous active-high reset, asynchronous pins.
 */
// Local design decision: register access over Avalon-MM.
// How it works
// - Bit 7 picks 16-bit or short PWM.
// - Bit 6 enables the module comparator.
// - Bit 5 captures on input rising edge.
// - Bit 4 captures on input falling edge.
// - Bit 3 sets flag on counter match.
// - Bit 2 toggles output pin on match.
// - Bit 1 drives PWM on output pin.
// - Toggle plus PWM gives frequency output.
// - Bit 0 masks the flag interrupt request.
// - Watchdog on locks module two mode register.
// - Watchdog on locks both counter bytes.
// - Counter is 16 bits, two byte registers.
// - High byte reads snapshot taken on low read.
// - Timebase field selects the counting source.
// - Watchdog enable resets to one, enables watchdog.
// - Cycle length field gives 8 to 11 bits.
`timescale 1ns/1ps
`include "acm_regs.svh"

module acm_array
	import acm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [2:0]  module_input_pin,
	input  wire logic        external_count_input,
	input  wire logic        ext_clock_pin,
	input  wire logic        rtc_clock_pin,
	input  wire logic        timer0_overflow,
	output logic      [2:0]  module_output_pin,
	output logic             watchdog_expired,
	output logic             irq
);
	localparam acm_byte_t MODE_IDX  [3] = '{`ACM_IDX_MODE0, `ACM_IDX_MODE1, `ACM_IDX_MODE2};
	localparam acm_byte_t CC_LO_IDX [3] = '{`ACM_IDX_CC_LO0, `ACM_IDX_CC_LO1, `ACM_IDX_CC_LO2};
	localparam acm_byte_t CC_HI_IDX [3] = '{`ACM_IDX_CC_HI0, `ACM_IDX_CC_HI1, `ACM_IDX_CC_HI2};

	acm_bus_t  bus_state, next_bus_state;
	acm_byte_t rdata, next_rdata;
	acm_byte_t mode [3];
	acm_byte_t next_mode [3];
	acm_word_t cc [3];
	acm_word_t next_cc [3];
	acm_word_t cnt, next_cnt;
	acm_byte_t snap, next_snap;
	logic [2:0] timebase, next_timebase;
	logic       watchdog_enable, next_watchdog_enable;
	logic [1:0] cycle_length_select, next_cycle_length_select;
	logic [2:0] capture_compare_flag, next_capture_compare_flag;
	logic [2:0] irq_mask, next_irq_mask;
	logic [2:0] pin_out, next_pin_out;
	logic [2:0] in_s1, in_s2, in_prev;
	logic [1:0] eci_s, ext_s, rtc_s;
	logic       eci_prev, ext_prev, rtc_prev;
	logic [3:0] pre12, next_pre12;
	logic [1:0] pre4, next_pre4;
	logic [2:0] ext_div, next_ext_div, rtc_div, next_rtc_div;
	logic       tick, tick_d, wdt_exp, next_wdt_exp;

	logic       req, take_read, take_write, wr_lo;
	acm_byte_t  idx, wbyte, rd_val;
	acm_word_t  pwm_mask;
	logic [2:0] hit, rise, fall;

	assign req             = avs_read | avs_write;
	assign idx             = avs_address[9:2];
	assign wbyte           = avs_writedata[7:0];
	assign wr_lo           = avs_byteenable[0];
	assign take_read       = avs_read & (bus_state == ACM_BUS_IDLE);
	assign take_write      = avs_write & wr_lo & (bus_state == ACM_BUS_ACK);
	assign avs_waitrequest = req & (bus_state != ACM_BUS_ACK);
	assign avs_readdata    = {24'h000000, rdata};
	assign module_output_pin = pin_out;
	assign watchdog_expired  = wdt_exp;
	assign irq = |(capture_compare_flag & irq_mask & {mode[2][`ACM_BIT_IRQ_MASK],
		mode[1][`ACM_BIT_IRQ_MASK], mode[0][`ACM_BIT_IRQ_MASK]});
	assign rise = in_s2 & ~in_prev;
	assign fall = ~in_s2 & in_prev;
	// Short PWM compares only the low 8 to 11 counter bits.
	assign pwm_mask = `ACM_PWM_MAX_MASK >> (`ACM_CLSEL_MAX - cycle_length_select);

	// Counting source and prescalers.
	always_comb begin
		next_pre12   = (pre12 == `ACM_DIV12_LAST) ? 4'h0 : pre12 + 4'h1;
		next_pre4    = pre4 + 2'h1;
		next_ext_div = ext_div + {2'h0, ext_s[1] & ~ext_prev};
		next_rtc_div = rtc_div + {2'h0, rtc_s[1] & ~rtc_prev};
		case (timebase)
			`ACM_TB_DIV12:    tick = (pre12 == `ACM_DIV12_LAST);
			`ACM_TB_DIV4:     tick = (pre4 == `ACM_DIV4_LAST);
			`ACM_TB_TIMER0:   tick = timer0_overflow;
			`ACM_TB_EXT_FALL: tick = ~eci_s[1] & eci_prev;
			`ACM_TB_SYSCLK:   tick = 1'b1;
			`ACM_TB_EXT_DIV8: tick = ext_s[1] & ~ext_prev & (ext_div == `ACM_DIV8_LAST);
			`ACM_TB_RTC_DIV8: tick = rtc_s[1] & ~rtc_prev & (rtc_div == `ACM_DIV8_LAST);
			default:          tick = 1'b0;
		endcase
	end

	// Register state, bus access and module behaviour.
	always_comb begin
		next_bus_state            = bus_state;
		next_rdata                = rdata;
		next_mode                 = mode;
		next_cc                   = cc;
		next_cnt                  = tick ? cnt + 16'h0001 : cnt;
		next_snap                 = snap;
		next_timebase             = timebase;
		next_watchdog_enable      = watchdog_enable;
		next_cycle_length_select  = cycle_length_select;
		next_capture_compare_flag = capture_compare_flag;
		next_irq_mask             = irq_mask;
		next_pin_out              = pin_out;
		next_wdt_exp              = 1'b0;
		rd_val                    = 8'h00;
		hit                       = 3'h0;

		case (bus_state)
			ACM_BUS_IDLE: if (req) next_bus_state = ACM_BUS_ACK;
			ACM_BUS_ACK:  next_bus_state = ACM_BUS_IDLE;
			default:      next_bus_state = ACM_BUS_IDLE;
		endcase

		case (idx)
			`ACM_IDX_IRQ_MASK:   rd_val = {5'h00, irq_mask};
			`ACM_IDX_FLAGS:      rd_val = {5'h00, capture_compare_flag};
			`ACM_IDX_ARRAY_MODE: rd_val = {1'b0, watchdog_enable, 2'h0, timebase, 1'b0};
			`ACM_IDX_CYCLE_LEN:  rd_val = {6'h00, cycle_length_select};
			`ACM_IDX_CNT_LO:     rd_val = cnt[7:0];
			`ACM_IDX_CNT_HI:     rd_val = snap;
			default: begin
				for (int i = 0; i < 3; i++) begin
					if (idx == MODE_IDX[i])  rd_val = mode[i];
					if (idx == CC_LO_IDX[i]) rd_val = cc[i][7:0];
					if (idx == CC_HI_IDX[i]) rd_val = cc[i][15:8];
				end
			end
		endcase
		if (take_read) begin
			next_rdata = rd_val;
			if (idx == `ACM_IDX_CNT_LO) next_snap = cnt[15:8];
		end

		if (take_write) begin
			case (idx)
				`ACM_IDX_IRQ_MASK:  next_irq_mask = wbyte[2:0];
				`ACM_IDX_FLAGS:     next_capture_compare_flag = capture_compare_flag & ~wbyte[2:0];
				`ACM_IDX_CYCLE_LEN: next_cycle_length_select = wbyte[1:0];
				`ACM_IDX_ARRAY_MODE: begin
					next_watchdog_enable = wbyte[`ACM_BIT_WDT_EN];
					if (!watchdog_enable) next_timebase = wbyte[`ACM_TB_MSB:`ACM_TB_LSB];
				end
				`ACM_IDX_CNT_LO: if (!watchdog_enable) next_cnt[7:0] = wbyte;
				`ACM_IDX_CNT_HI: if (!watchdog_enable) next_cnt[15:8] = wbyte;
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (idx == MODE_IDX[i] && !(watchdog_enable && i == `ACM_WDT_MODULE))
							next_mode[i] = wbyte;
						if (idx == CC_LO_IDX[i]) begin
							next_cc[i][7:0] = wbyte;
							if (!(watchdog_enable && i == `ACM_WDT_MODULE))
								next_mode[i][`ACM_BIT_CMP_EN] = 1'b0;
						end
						if (idx == CC_HI_IDX[i]) begin
							next_cc[i][15:8] = wbyte;
							if (!(watchdog_enable && i == `ACM_WDT_MODULE))
								next_mode[i][`ACM_BIT_CMP_EN] = 1'b1;
						end
					end
				end
			endcase
		end

		for (int i = 0; i < 3; i++) begin
			if (watchdog_enable && i == `ACM_WDT_MODULE) begin
				// The watchdog module fires when the high bytes meet.
				next_wdt_exp = tick_d & (cnt[15:8] == cc[i][15:8]);
			end else if (mode[i][`ACM_BIT_CMP_EN]) begin
				if (mode[i][`ACM_BIT_TOGGLE] && mode[i][`ACM_BIT_PWM]) begin
					// Frequency output: toggle and step the low compare byte.
					hit[i] = tick_d & (cnt[7:0] == cc[i][7:0]);
					if (hit[i]) begin
						next_pin_out[i] = ~pin_out[i];
						next_cc[i][7:0] = cc[i][7:0] + cc[i][15:8];
					end
				end else if (mode[i][`ACM_BIT_PWM]) begin
					if (mode[i][`ACM_BIT_WIDE_PWM]) begin
						hit[i] = tick_d & (cnt == cc[i]);
						next_pin_out[i] = (cnt < cc[i]);
					end else begin
						hit[i] = tick_d & ((cnt & pwm_mask) == (cc[i] & pwm_mask));
						next_pin_out[i] = ((cnt & pwm_mask) < (cc[i] & pwm_mask));
					end
				end else begin
					hit[i] = tick_d & (cnt == cc[i]);
					if (hit[i] && mode[i][`ACM_BIT_TOGGLE])
						next_pin_out[i] = ~pin_out[i];
				end
				if (hit[i] && mode[i][`ACM_BIT_MATCH_FLAG])
					next_capture_compare_flag[i] = 1'b1;
			end
			// Capture wins over a same-cycle bus write, and any set wins over a clear.
			if ((rise[i] && mode[i][`ACM_BIT_RISE_CAP]) ||
			    (fall[i] && mode[i][`ACM_BIT_FALL_CAP])) begin
				next_cc[i] = cnt;
				next_capture_compare_flag[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		in_s1    <= module_input_pin;
		in_s2    <= in_s1;
		in_prev  <= in_s2;
		eci_s    <= {eci_s[0], external_count_input};
		ext_s    <= {ext_s[0], ext_clock_pin};
		rtc_s    <= {rtc_s[0], rtc_clock_pin};
		eci_prev <= eci_s[1];
		ext_prev <= ext_s[1];
		rtc_prev <= rtc_s[1];
		if (sys_rst) begin
			bus_state            <= ACM_BUS_IDLE;
			rdata                <= `ACM_RST_BYTE;
			mode                 <= '{`ACM_RST_MODE, `ACM_RST_MODE, `ACM_RST_MODE};
			cc                   <= '{`ACM_RST_WORD, `ACM_RST_WORD, `ACM_RST_WORD};
			cnt                  <= `ACM_RST_WORD;
			snap                 <= `ACM_RST_BYTE;
			timebase             <= `ACM_RST_TIMEBASE;
			watchdog_enable      <= `ACM_RST_WDT_EN;
			cycle_length_select  <= 2'h0;
			capture_compare_flag <= 3'h0;
			irq_mask             <= 3'h0;
			pin_out              <= 3'h0;
			pre12                <= 4'h0;
			pre4                 <= 2'h0;
			ext_div              <= 3'h0;
			rtc_div              <= 3'h0;
			tick_d               <= 1'b0;
			wdt_exp              <= 1'b0;
		end else begin
			bus_state            <= next_bus_state;
			rdata                <= next_rdata;
			mode                 <= next_mode;
			cc                   <= next_cc;
			cnt                  <= next_cnt;
			snap                 <= next_snap;
			timebase             <= next_timebase;
			watchdog_enable      <= next_watchdog_enable;
			cycle_length_select  <= next_cycle_length_select;
			capture_compare_flag <= next_capture_compare_flag;
			irq_mask             <= next_irq_mask;
			pin_out              <= next_pin_out;
			pre12                <= next_pre12;
			pre4                 <= next_pre4;
			ext_div              <= next_ext_div;
			rtc_div              <= next_rtc_div;
			tick_d               <= tick;
			wdt_exp              <= next_wdt_exp;
		end
	end

	// Checks on module 0 and 1 behaviour, the bus and the watchdog locks.
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_WIDE_PWM: assert property (mode[1][`ACM_BIT_CMP_EN] && mode[1][`ACM_BIT_PWM] &&
		mode[1][`ACM_BIT_WIDE_PWM] && !mode[1][`ACM_BIT_TOGGLE]
		|=> module_output_pin[1] == ($past(cnt) < $past(cc[1])))
		else $error("16-bit PWM output wrong");
	AST_CMP_OFF: assert property (!mode[0][`ACM_BIT_CMP_EN] |=> $stable(module_output_pin[0]))
		else $error("Output moved with comparator off");
	AST_RISE_CAP: assert property (mode[0][`ACM_BIT_RISE_CAP] && in_s2[0] && !in_prev[0]
		|=> cc[0] == $past(cnt) && capture_compare_flag[0])
		else $error("Rising capture missed");
	AST_FALL_CAP: assert property (mode[1][`ACM_BIT_FALL_CAP] && !in_s2[1] && in_prev[1]
		|=> cc[1] == $past(cnt) && capture_compare_flag[1])
		else $error("Falling capture missed");
	AST_MATCH_FLAG: assert property (mode[0][`ACM_BIT_CMP_EN] && mode[0][`ACM_BIT_MATCH_FLAG] &&
		!mode[0][`ACM_BIT_PWM] && tick_d && cnt == cc[0] |=> capture_compare_flag[0])
		else $error("Match flag not set");
	AST_TOGGLE: assert property (mode[0][`ACM_BIT_CMP_EN] && mode[0][`ACM_BIT_TOGGLE] &&
		!mode[0][`ACM_BIT_PWM] && tick_d && cnt == cc[0]
		|=> module_output_pin[0] != $past(module_output_pin[0]))
		else $error("Toggle on match missed");
	AST_IRQ: assert property (capture_compare_flag[0] && mode[0][`ACM_BIT_IRQ_MASK] && irq_mask[0]
		|-> irq)
		else $error("Interrupt not raised");
	AST_WDT_MODE_LOCK: assert property (watchdog_enable && take_write && idx == `ACM_IDX_MODE2
		|=> mode[2] == $past(mode[2]))
		else $error("Watchdog mode register changed");
	AST_CNT_LOCK: assert property (watchdog_enable && take_write && idx == `ACM_IDX_CNT_HI && !tick
		|=> cnt == $past(cnt))
		else $error("Counter written while locked");
	AST_SNAPSHOT: assert property (take_read && idx == `ACM_IDX_CNT_LO
		|=> snap == $past(cnt[15:8]) ##1 (avs_readdata[7:0] == $past(cnt[7:0], 2)))
		else $error("Snapshot not taken on low read");
	AST_WDT_RESET: assert property ($fell(sys_rst) |-> watchdog_enable)
		else $error("Watchdog enable not one after reset");
	AST_SHORT_PWM: assert property (mode[1][`ACM_BIT_CMP_EN] && mode[1][`ACM_BIT_PWM] &&
		!mode[1][`ACM_BIT_WIDE_PWM] && !mode[1][`ACM_BIT_TOGGLE]
		|=> module_output_pin[1] == ($past(cnt & pwm_mask) < $past(cc[1] & pwm_mask)))
		else $error("Short PWM output wrong");
	AST_FREQ_OUT: assert property (mode[1][`ACM_BIT_CMP_EN] && mode[1][`ACM_BIT_PWM] &&
		mode[1][`ACM_BIT_TOGGLE] && tick_d && cnt[7:0] == cc[1][7:0]
		|=> module_output_pin[1] != $past(module_output_pin[1]))
		else $error("Frequency output toggle missed");
	AST_WDT_PULSE: assert property (watchdog_enable && tick_d && cnt[15:8] == cc[2][15:8]
		|=> watchdog_expired)
		else $error("Watchdog pulse missed");
	AST_CC_LO_CLEARS: assert property (take_write && idx == `ACM_IDX_CC_LO0 |=> !mode[0][`ACM_BIT_CMP_EN])
		else $error("Compare enable not cleared");
	AST_NO_IRQ: assert property (!mode[0][`ACM_BIT_IRQ_MASK] && !mode[1][`ACM_BIT_IRQ_MASK] &&
		!mode[2][`ACM_BIT_IRQ_MASK] |-> !irq)
		else $error("Interrupt raised while masked");
	AST_SNAP_HOLD: assert property (!(take_read && idx == `ACM_IDX_CNT_LO) |=> $stable(snap))
		else $error("Snapshot changed without low read");

	COV_CAPTURE: cover property (mode[0][`ACM_BIT_RISE_CAP] && rise[0]);
	COV_FREQ: cover property (mode[1][`ACM_BIT_TOGGLE] && mode[1][`ACM_BIT_PWM] && hit[1]);
	COV_WDT: cover property (wdt_exp);
	COV_IRQ: cover property ($rose(irq));
endmodule

// >>> common/acm_regs.svh
/*
 * Register indices, field positions, reset values and divider counts of the
 * counter array. Assumes the byte address on the bus is four times an index.
 */
`ifndef ACM_REGS_SVH
`define ACM_REGS_SVH

`define ACM_IDX_IRQ_MASK    8'hD7
`define ACM_IDX_FLAGS       8'hD8
`define ACM_IDX_ARRAY_MODE  8'hD9
`define ACM_IDX_MODE0       8'hDA
`define ACM_IDX_MODE1       8'hDB
`define ACM_IDX_MODE2       8'hDC
`define ACM_IDX_CYCLE_LEN   8'hDF
`define ACM_IDX_CNT_LO      8'hF9
`define ACM_IDX_CNT_HI      8'hFA
`define ACM_IDX_CC_LO0      8'hFB
`define ACM_IDX_CC_HI0      8'hFC
`define ACM_IDX_CC_LO1      8'hE9
`define ACM_IDX_CC_HI1      8'hEA
`define ACM_IDX_CC_LO2      8'hEB
`define ACM_IDX_CC_HI2      8'hEC

`define ACM_BIT_WIDE_PWM    7
`define ACM_BIT_CMP_EN      6
`define ACM_BIT_RISE_CAP    5
`define ACM_BIT_FALL_CAP    4
`define ACM_BIT_MATCH_FLAG  3
`define ACM_BIT_TOGGLE      2
`define ACM_BIT_PWM         1
`define ACM_BIT_IRQ_MASK    0

`define ACM_BIT_WDT_EN      6
`define ACM_TB_MSB          3
`define ACM_TB_LSB          1
`define ACM_WDT_MODULE      2

`define ACM_RST_MODE        8'h00
`define ACM_RST_BYTE        8'h00
`define ACM_RST_WORD        16'h0000
`define ACM_RST_TIMEBASE    3'h0
`define ACM_RST_WDT_EN      1'b1

`define ACM_TB_DIV12        3'h0
`define ACM_TB_DIV4         3'h1
`define ACM_TB_TIMER0       3'h2
`define ACM_TB_EXT_FALL     3'h3
`define ACM_TB_SYSCLK       3'h4
`define ACM_TB_EXT_DIV8     3'h5
`define ACM_TB_RTC_DIV8     3'h6

`define ACM_DIV12_LAST      4'hB
`define ACM_DIV4_LAST       2'h3
`define ACM_DIV8_LAST       3'h7
`define ACM_PWM_MAX_MASK    16'h07FF
`define ACM_CLSEL_MAX       2'h3

`endif

// >>> common/acm_pkg.sv
/*
 * Types of the counter array block.
 * Assumes acm_regs.svh supplies the numeric constants.
 */
package acm_pkg;
	typedef enum logic [1:0] {
		ACM_BUS_IDLE = 2'b01,
		ACM_BUS_ACK  = 2'b10
	} acm_bus_t;
	typedef logic [7:0]  acm_byte_t;
	typedef logic [15:0] acm_word_t;
endpackage

// >>> sim/acm_pins.sv
/*
 * Pin-side model of the counter array: capture inputs, count pins and timer overflow.
 * Assumes the bench sets the capture levels and that all pins are asynchronous.
 */
`timescale 1ns/1ps
module acm_pins (
	input  wire logic       clk,
	input  wire logic [2:0] cap_level,
	output logic      [2:0] module_input_pin,
	output logic            external_count_input,
	output logic            ext_clock_pin,
	output logic            rtc_clock_pin,
	output logic            timer0_overflow
);
	logic [4:0] div;
	initial begin
		div = 5'h00;
		module_input_pin = 3'h0;
		timer0_overflow = 1'b0;
	end
	// Capture pins change off the clock grid, as real external signals do.
	always @(cap_level) begin
		module_input_pin <= #7 cap_level;
	end
	always @(posedge clk) begin
		div <= div + 5'h01;
		timer0_overflow <= (div == 5'h1F);
	end
	assign external_count_input = div[2];
	assign ext_clock_pin = div[1];
	assign rtc_clock_pin = div[3];
endmodule

// >>> sim/array_capture_compare_modes_tb.sv
/*
 * Self-checking bench of the counter array: register bus, capture, match and PWM.
 * Assumes the one-wait-state bus slave and pin model described beside it.
 */
`timescale 1ns/1ps
`include "acm_regs.svh"
module array_capture_compare_modes_tb import acm_pkg::*;;
	logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, p0;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic [2:0]  cap_level, module_input_pin, module_output_pin;
	logic        external_count_input, ext_clock_pin, rtc_clock_pin, timer0_overflow, watchdog_expired;
	logic [15:0] notes[$];
	logic [15:0] nt;
	acm_byte_t   v;
	int          errors, checked, cycles;

	acm_array dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .module_input_pin(module_input_pin),
		.external_count_input(external_count_input), .ext_clock_pin(ext_clock_pin),
		.rtc_clock_pin(rtc_clock_pin), .timer0_overflow(timer0_overflow),
		.module_output_pin(module_output_pin), .watchdog_expired(watchdog_expired), .irq(irq));
	acm_pins pins (.clk(clk), .cap_level(cap_level), .module_input_pin(module_input_pin),
		.external_count_input(external_count_input), .ext_clock_pin(ext_clock_pin),
		.rtc_clock_pin(rtc_clock_pin), .timer0_overflow(timer0_overflow));

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", name, exp, got);
		end
	endtask

	task automatic test_done;
		if (notes.size() != 0) begin
			errors++;
			$display("BAD notes left exp 0 got %0d", notes.size());
		end
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Holds the request until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input acm_byte_t idx, input acm_byte_t d);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, d};
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input acm_byte_t idx, input acm_byte_t d);
		bus(1'b1, idx, d);
	endtask

	task automatic rd(input acm_byte_t idx, input acm_byte_t exp);
		notes.push_back({idx, exp});
		bus(1'b0, idx, 8'h00);
	endtask

	task automatic pwm_count(input int n, input int exp);
		int hi;
		hi = 0;
		repeat (4) @(posedge clk);
		repeat (n) begin
			@(negedge clk);
			hi += module_output_pin[1];
		end
		@(posedge clk);
		check("pwm high cycles", exp, hi);
	endtask

	// Compares each completed read with the oldest expectation.
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (notes.size() == 0) begin
				errors++;
				$display("BAD read unexpected exp none got %h", avs_readdata);
			end else begin
				nt = notes.pop_front();
				check("readdata", {24'h000000, nt[7:0]}, avs_readdata);
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			$display("BAD timeout exp done got hang");
			test_done();
		end
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		sys_rst = 1'b1;
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		cap_level = 3'h0;
		errors = 0;
		checked = 0;
		cycles = 0;
		void'($urandom(39));
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		p0 = 1'b0;
		repeat (30) begin
			@(negedge clk);
			if (watchdog_expired === 1'b1) p0 = 1'b1;
		end
		@(posedge clk);
		check("watchdog pulse", 32'h1, {31'h0, p0});
		rd(`ACM_IDX_CNT_HI, 8'h00);
		rd(`ACM_IDX_MODE0, 8'h00);
		rd(`ACM_IDX_MODE2, 8'h00);
		rd(`ACM_IDX_ARRAY_MODE, 8'h40);
		rd(8'h00, 8'h00);
		wr(`ACM_IDX_MODE2, 8'hFF);
		rd(`ACM_IDX_MODE2, 8'h00);
		wr(`ACM_IDX_ARRAY_MODE, 8'h0E);
		rd(`ACM_IDX_ARRAY_MODE, 8'h00);
		wr(`ACM_IDX_ARRAY_MODE, 8'h0E);
		rd(`ACM_IDX_ARRAY_MODE, 8'h0E);
		wr(`ACM_IDX_CNT_LO, 8'h12);
		wr(`ACM_IDX_CNT_HI, 8'h34);
		wr(`ACM_IDX_ARRAY_MODE, 8'h4E);
		wr(`ACM_IDX_CNT_LO, 8'h99);
		wr(`ACM_IDX_CNT_HI, 8'h99);
		rd(`ACM_IDX_CNT_LO, 8'h12);
		rd(`ACM_IDX_CNT_HI, 8'h34);
		wr(`ACM_IDX_ARRAY_MODE, 8'h0E);
		wr(`ACM_IDX_CNT_HI, 8'h56);
		rd(`ACM_IDX_CNT_HI, 8'h34);
		rd(`ACM_IDX_CNT_LO, 8'h12);
		rd(`ACM_IDX_CNT_HI, 8'h56);
		repeat (4) begin
			v = acm_byte_t'($urandom());
			wr(`ACM_IDX_MODE1, v);
			rd(`ACM_IDX_MODE1, v);
		end
		wr(`ACM_IDX_MODE0, 8'h21);
		wr(`ACM_IDX_MODE1, 8'h10);
		wr(`ACM_IDX_FLAGS, 8'h07);
		wr(`ACM_IDX_IRQ_MASK, 8'h07);
		cap_level <= 3'b011;
		repeat (8) @(posedge clk);
		rd(`ACM_IDX_FLAGS, 8'h01);
		rd(`ACM_IDX_CC_LO0, 8'h12);
		rd(`ACM_IDX_CC_HI0, 8'h56);
		@(negedge clk);
		check("irq", 32'h1, {31'h0, irq});
		@(posedge clk);
		cap_level <= 3'b000;
		repeat (8) @(posedge clk);
		rd(`ACM_IDX_FLAGS, 8'h03);
		rd(`ACM_IDX_CC_HI1, 8'h56);
		wr(`ACM_IDX_MODE0, 8'h20);
		@(negedge clk);
		check("irq", 32'h0, {31'h0, irq});
		@(posedge clk);
		wr(`ACM_IDX_FLAGS, 8'h03);
		rd(`ACM_IDX_FLAGS, 8'h00);
		wr(`ACM_IDX_MODE0, 8'h00);
		wr(`ACM_IDX_MODE1, 8'h00);
		wr(`ACM_IDX_CNT_LO, 8'hF0);
		wr(`ACM_IDX_CNT_HI, 8'h00);
		wr(`ACM_IDX_CC_LO0, 8'h00);
		wr(`ACM_IDX_CC_HI0, 8'h01);
		wr(`ACM_IDX_MODE0, 8'h4C);
		@(negedge clk);
		p0 = module_output_pin[0];
		@(posedge clk);
		wr(`ACM_IDX_ARRAY_MODE, 8'h08);
		repeat (40) @(posedge clk);
		wr(`ACM_IDX_ARRAY_MODE, 8'h0E);
		rd(`ACM_IDX_FLAGS, 8'h01);
		@(negedge clk);
		check("toggle pin", {31'h0, !p0}, {31'h0, module_output_pin[0]});
		@(posedge clk);
		wr(`ACM_IDX_MODE0, 8'h00);
		wr(`ACM_IDX_CC_LO1, 8'h80);
		wr(`ACM_IDX_CC_HI1, 8'h01);
		wr(`ACM_IDX_CNT_LO, 8'h00);
		wr(`ACM_IDX_CNT_HI, 8'h00);
		wr(`ACM_IDX_MODE1, 8'hC2);
		wr(`ACM_IDX_ARRAY_MODE, 8'h08);
		pwm_count(256, 256);
		wr(`ACM_IDX_MODE1, 8'h42);
		pwm_count(256, 128);
		wr(`ACM_IDX_CYCLE_LEN, 8'h01);
		pwm_count(512, 384);
		wr(`ACM_IDX_ARRAY_MODE, 8'h0E);
		wr(`ACM_IDX_CNT_LO, 8'h00);
		wr(`ACM_IDX_CNT_HI, 8'h00);
		wr(`ACM_IDX_CC_LO1, 8'h02);
		wr(`ACM_IDX_CC_HI1, 8'h10);
		wr(`ACM_IDX_MODE1, 8'h46);
		wr(`ACM_IDX_ARRAY_MODE, 8'h08);
		pwm_count(256, 128);
		test_done();
	end
endmodule
